// ---- src/sdsq_map.svh ----
// Purpose: constants of the serial display settings and query block
// Assumes: 50 MHz mclk, 8-bit serial bytes
// Notes: codes of commands handled here, indices, defaults and timing
`ifndef SDSQ_MAP_SVH
`define SDSQ_MAP_SVH
`define SDSQ_PREFIX 8'h7C
`define SDSQ_CMD_QUERY 8'h21
`define SDSQ_CMD_SET 8'h22
`define SDSQ_CMD_REVERSE 8'h12
`define SDSQ_CMD_RESET 8'h08
`define SDSQ_CHR_LF 8'h0A
`define SDSQ_CHR_CR 8'h0D
`define SDSQ_CHR_XON 8'h11
`define SDSQ_CHR_XOFF 8'h13
`define SDSQ_ERR_BYTE 8'hFF
`define SDSQ_IDX_MARKER 8'h00
`define SDSQ_IDX_BAUD 8'h01
`define SDSQ_IDX_BACKLIGHT 8'h02
`define SDSQ_IDX_SPLASH 8'h03
`define SDSQ_IDX_INVERT 8'h04
`define SDSQ_IDX_RESERVED 8'h05
`define SDSQ_IDX_LINE_END 8'h06
`define SDSQ_IDX_RESUME 8'h07
`define SDSQ_IDX_STOP 8'h08
`define SDSQ_IDX_SCROLL 8'h09
`define SDSQ_IDX_LARGE 8'h0A
`define SDSQ_IDX_FW_MAJOR 8'h20
`define SDSQ_IDX_FW_MINOR 8'h21
`define SDSQ_IDX_SPR_BYTES 8'h22
`define SDSQ_IDX_WIDTH 8'h40
`define SDSQ_IDX_HEIGHT 8'h41
`define SDSQ_IDX_SPR0_H 8'h81
`define SDSQ_NUM_SETTINGS 11
`define SDSQ_DEF_MARKER 8'h5A
`define SDSQ_DEF_BAUD 8'h06
`define SDSQ_DEF_BACKLIGHT 8'h64
`define SDSQ_DEF_RESUME 8'h08
`define SDSQ_DEF_STOP 8'h18
`define SDSQ_DEF_ZERO 8'h00
`define SDSQ_CLK_MHZ 50
`define SDSQ_WDOG_TIME_US 16000
`endif

// ---- src/sdsq_pkg.sv ----
// Purpose: types of the serial display settings and query block
// Assumes: constants come from sdsq_map.svh
// Notes: interpreter states are gray coded along text-code-index-value
package sdsq_pkg;
	typedef enum logic [2:0] {
		ST_TEXT = 3'h0,
		ST_CODE = 3'h1,
		ST_IDX = 3'h3,
		ST_VAL = 3'h2,
		ST_WDOG = 3'h6
	} sdsq_state_t;
	typedef logic [7:0] sdsq_byte_t;
endpackage

// ---- src/sdsq_top.sv ----
// Purpose: settings table, query, flow control and reset of a serial display
// Assumes: received bytes arrive synchronous to mclk from a uart receiver
// Notes: drawing commands are forwarded to other blocks byte by byte
// Operation
// - indices 0-4: marker, baud, backlight, splash, invert
// - index five reserved, no behaviour
// - firmware and geometry indices read only
// - sprite size and sprite zero height read only
// - query answered by exactly one byte
// - set stores byte unchecked
// - stored invert flag inverts screen only at watchdog reset
// - line end mode picks line feed motion
// - line end mode defaults to zero
// - no scroll: wrap cursor to top
// - scroll: shift up, clear bottom line
// - stop and resume fill positions drive XOFF/XON
// - still backlogged: XOFF again on next byte
// - reset drops sprites, restores transient states
// - pending argument bytes finish before reset
// - reset by watchdog expiry, keeps settings unlike power-on
// - commands start with prefix byte 7C
`include "sdsq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sdsq_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [$clog2(DEPTH+1)-1:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];
	assign count = cnt_r;
	always_ff @(posedge mclk) begin
		if (push)
			mem[wp_r] <= in_data;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (flush) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= push ? AW'(wp_r + 1'b1) : wp_r;
			rp_r <= pop ? AW'(rp_r + 1'b1) : rp_r;
			cnt_r <= cnt_r + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
		end
	end
endmodule // sdsq_fifo

module sdsq_top import sdsq_pkg::*; #(
	parameter int FIFO_DEPTH = 32,
	parameter int COLS = 21,
	parameter int ROWS = 8,
	parameter int WDOG_CYCLES = `SDSQ_WDOG_TIME_US * `SDSQ_CLK_MHZ,
	parameter logic [7:0] FW_MAJOR = 8'h01, // arbitrary value
	parameter logic [7:0] FW_MINOR = 8'h00, // arbitrary value
	parameter logic [7:0] SPR_BYTES = 8'h80,
	parameter logic [7:0] WIDTH_PX = 8'h80,
	parameter logic [7:0] HEIGHT_PX = 8'h40,
	parameter logic [7:0] SPR0_HEIGHT = 8'h08
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	input wire logic args_pending,
	output logic fwd_valid,
	output logic [7:0] fwd_data,
	output logic fwd_is_code,
	output logic invert_active,
	output logic sprite_clear,
	output logic scroll_up,
	output logic query_error,
	output logic [7:0] cursor_col,
	output logic [7:0] cursor_row,
	output logic [7:0] baud_sel,
	output logic [7:0] backlight,
	output logic [7:0] large_screen
);
	localparam int CW = $clog2(FIFO_DEPTH+1);
	sdsq_state_t st_r, st_nxt;
	sdsq_byte_t table_r [`SDSQ_NUM_SETTINGS];
	sdsq_byte_t idx_r;
	logic [CW-1:0] cnt;
	logic [$clog2(WDOG_CYCLES+1)-1:0] wdog_r;
	logic f_valid, f_ready, push, stop_r, xoff_pend_r, xon_pend_r, rep_pend_r, tx_load;
	sdsq_byte_t f_data, rep_data_r;

	// lookup of every queryable index, bit 8 flags a defined index
	function automatic logic [8:0] lookup(input sdsq_byte_t idx);
		if (idx < 8'(`SDSQ_NUM_SETTINGS) && idx != `SDSQ_IDX_RESERVED)
			return {1'b1, table_r[idx[3:0]]};
		else if (idx == `SDSQ_IDX_FW_MAJOR)
			return {1'b1, FW_MAJOR};
		else if (idx == `SDSQ_IDX_FW_MINOR)
			return {1'b1, FW_MINOR};
		else if (idx == `SDSQ_IDX_SPR_BYTES)
			return {1'b1, SPR_BYTES};
		else if (idx == `SDSQ_IDX_WIDTH)
			return {1'b1, WIDTH_PX};
		else if (idx == `SDSQ_IDX_HEIGHT)
			return {1'b1, HEIGHT_PX};
		else if (idx == `SDSQ_IDX_SPR0_H)
			return {1'b1, SPR0_HEIGHT};
		return {1'b0, `SDSQ_ERR_BYTE};
	endfunction

	wire wdog_done = (st_r == ST_WDOG) && (wdog_r == '0);
	assign push = rx_valid && rx_ready;
	sdsq_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.flush(wdog_done),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data),
		.count(cnt)
	);

	// one byte at a time, in arrival order; reply back-pressures the queue
	assign f_ready = (st_r != ST_WDOG) && !rep_pend_r;
	wire pop = f_valid && f_ready;
	// bytes owed to a variable-length command go out before any parsing
	wire pass = pop && args_pending;
	wire parse = pop && !args_pending;
	wire is_prefix = (f_data == `SDSQ_PREFIX);
	wire text_byte = parse && (st_r == ST_TEXT) && !is_prefix;
	wire code_byte = parse && (st_r == ST_CODE);
	wire is_query = code_byte && (f_data == `SDSQ_CMD_QUERY);
	wire is_set = code_byte && (f_data == `SDSQ_CMD_SET);
	wire is_rev = code_byte && (f_data == `SDSQ_CMD_REVERSE);
	wire is_rst = code_byte && (f_data == `SDSQ_CMD_RESET);
	wire is_other = code_byte && !is_query && !is_set && !is_rev && !is_rst;
	wire idx_byte = parse && (st_r == ST_IDX);
	wire val_byte = parse && (st_r == ST_VAL);
	wire [8:0] look = lookup(f_data);
	wire q_done = idx_byte && (idx_r == `SDSQ_CMD_QUERY);
	wire s_take = idx_byte && (idx_r == `SDSQ_CMD_SET);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_TEXT: begin
				if (parse && is_prefix)
					st_nxt = ST_CODE;
			end
			ST_CODE: begin
				if (is_query || is_set)
					st_nxt = ST_IDX;
				else if (is_rst)
					st_nxt = ST_WDOG;
				else if (parse)
					st_nxt = ST_TEXT;
			end
			ST_IDX: begin
				if (s_take)
					st_nxt = ST_VAL;
				else if (parse)
					st_nxt = ST_TEXT;
			end
			ST_VAL: begin
				if (parse)
					st_nxt = ST_TEXT;
			end
			ST_WDOG: begin
				if (wdog_done)
					st_nxt = ST_TEXT;
			end
			default: st_nxt = ST_TEXT;
		endcase
	end

	// idx_r holds the command code in ST_IDX and the index in ST_VAL
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= ST_TEXT;
			idx_r <= 8'h00;
			wdog_r <= '0;
		end else begin
			st_r <= st_nxt;
			idx_r <= (code_byte || idx_byte) ? f_data : idx_r;
			wdog_r <= is_rst ? ($clog2(WDOG_CYCLES+1))'(WDOG_CYCLES - 1) :
				(wdog_r != '0 ? wdog_r - 1'b1 : wdog_r);
		end
	end

	// settings survive the watchdog reset, only power-on loads defaults
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			table_r[0] <= `SDSQ_DEF_MARKER;
			table_r[1] <= `SDSQ_DEF_BAUD;
			table_r[2] <= `SDSQ_DEF_BACKLIGHT;
			table_r[3] <= `SDSQ_DEF_ZERO;
			table_r[4] <= `SDSQ_DEF_ZERO;
			table_r[5] <= `SDSQ_DEF_ZERO;
			table_r[6] <= `SDSQ_DEF_ZERO;
			table_r[7] <= `SDSQ_DEF_RESUME;
			table_r[8] <= `SDSQ_DEF_STOP;
			table_r[9] <= `SDSQ_DEF_ZERO;
			table_r[10] <= `SDSQ_DEF_ZERO;
		end else if (val_byte && idx_r < 8'(`SDSQ_NUM_SETTINGS)) begin
			table_r[idx_r[3:0]] <= f_data; // no range
		end
	end
	assign baud_sel = table_r[1];
	assign backlight = table_r[2];
	assign large_screen = table_r[10];

	// query reply, error byte for undefined index
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rep_pend_r <= 1'b0;
			rep_data_r <= 8'h00;
			query_error <= 1'b0;
		end else begin
			rep_pend_r <= q_done | (rep_pend_r & ~(tx_load && !xoff_pend_r && !xon_pend_r));
			rep_data_r <= q_done ? look[7:0] : rep_data_r;
			query_error <= q_done && !look[8];
		end
	end

	// flow control from fill level against the stored positions
	wire over_stop = cnt >= CW'(table_r[8]);
	wire under_resume = cnt <= CW'(table_r[7]);
	wire xoff_set = (!stop_r && over_stop) || (stop_r && push && !under_resume);
	wire xon_set = stop_r && under_resume && !xoff_set;
	assign tx_load = !tx_valid || tx_ready;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stop_r <= 1'b0;
			xoff_pend_r <= 1'b0;
			xon_pend_r <= 1'b0;
		end else if (wdog_done) begin
			stop_r <= 1'b0;
			xoff_pend_r <= 1'b0;
			xon_pend_r <= 1'b0;
		end else begin
			stop_r <= xoff_set ? 1'b1 : (xon_set ? 1'b0 : stop_r);
			xoff_pend_r <= xoff_set | (xoff_pend_r & ~tx_load);
			xon_pend_r <= xon_set | (xon_pend_r & ~(tx_load && !xoff_pend_r));
		end
	end

	// flow bytes overtake a waiting reply so the host stalls promptly
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else if (tx_load) begin
			tx_valid <= xoff_pend_r || xon_pend_r || rep_pend_r;
			tx_data <= xoff_pend_r ? `SDSQ_CHR_XOFF : (xon_pend_r ? `SDSQ_CHR_XON : rep_data_r);
		end
	end

	// text cursor; line feed motion follows the line end mode
	wire lf_home = (table_r[6] == 8'h00);
	wire is_lf = text_byte && (f_data == `SDSQ_CHR_LF);
	wire is_cr = text_byte && (f_data == `SDSQ_CHR_CR);
	wire wrap = text_byte && !is_lf && !is_cr && (cursor_col == 8'(COLS - 1));
	wire adv_row = is_lf || wrap;
	wire last_row = (cursor_row == 8'(ROWS - 1));
	wire scroll_on = (table_r[9] != 8'h00);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cursor_col <= 8'h00;
			cursor_row <= 8'h00;
			scroll_up <= 1'b0;
		end else if (wdog_done) begin
			cursor_col <= 8'h00;
			cursor_row <= 8'h00;
			scroll_up <= 1'b0;
		end else begin
			if (is_cr || wrap || (is_lf && lf_home))
				cursor_col <= 8'h00;
			else if (text_byte && !is_lf)
				cursor_col <= cursor_col + 8'h01;
			if (adv_row && !last_row)
				cursor_row <= cursor_row + 8'h01;
			else if (adv_row && !scroll_on)
				cursor_row <= 8'h00;
			scroll_up <= adv_row && last_row && scroll_on;
		end
	end

	// forward path for drawing blocks; reverse acts on screen only
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fwd_valid <= 1'b0;
			fwd_data <= 8'h00;
			fwd_is_code <= 1'b0;
			invert_active <= 1'b0;
			sprite_clear <= 1'b0;
		end else begin
			fwd_valid <= pass || is_other || (text_byte && !is_lf && !is_cr);
			fwd_data <= (pass || parse) ? f_data : fwd_data;
			fwd_is_code <= is_other;
			if (wdog_done)
				invert_active <= (table_r[4] != 8'h00);
			else if (is_rev)
				invert_active <= 1'b1;
			else if (val_byte && idx_r == `SDSQ_CMD_REVERSE)
				invert_active <= 1'b0;
			sprite_clear <= wdog_done;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	property p_xoff_at_stop;
		!stop_r && over_stop && !wdog_done |=> stop_r && (xoff_pend_r || tx_data == `SDSQ_CHR_XOFF);
	endproperty
	a_xoff_at_stop: assert property (p_xoff_at_stop) else $error("xoff not raised at stop position");
	property p_resend_xoff;
		stop_r && push && !under_resume && !wdog_done |=> xoff_pend_r;
	endproperty
	a_resend_xoff: assert property (p_resend_xoff) else $error("xoff not resent while backlogged");
	property p_set_store;
		val_byte && idx_r == `SDSQ_IDX_BACKLIGHT |=> backlight == $past(f_data);
	endproperty
	a_set_store: assert property (p_set_store) else $error("set did not store value");
	property p_set_invert;
		val_byte && idx_r == `SDSQ_IDX_INVERT |=> $stable(invert_active);
	endproperty
	a_set_invert: assert property (p_set_invert) else $error("stored flag changed screen");
	property p_reply;
		q_done |=> rep_pend_r && rep_data_r == $past(look[7:0]) ##[1:30] (tx_valid && tx_data == rep_data_r);
	endproperty
	a_reply: assert property (p_reply) else $error("query reply missing");
	property p_err;
		q_done && !look[8] |=> query_error && rep_data_r == `SDSQ_ERR_BYTE;
	endproperty
	a_err: assert property (p_err) else $error("undefined index not flagged");
	property p_lf_home;
		is_lf && lf_home && !wdog_done |=> cursor_col == 8'h00;
	endproperty
	a_lf_home: assert property (p_lf_home) else $error("line feed did not return column");
	property p_wrap_top;
		adv_row && last_row && !scroll_on && !wdog_done |=> cursor_row == 8'h00 && !scroll_up;
	endproperty
	a_wrap_top: assert property (p_wrap_top) else $error("cursor did not wrap to top");
	property p_scroll;
		adv_row && last_row && scroll_on && !wdog_done |=> scroll_up && cursor_row == 8'(ROWS - 1);
	endproperty
	a_scroll: assert property (p_scroll) else $error("scroll not requested");
	property p_wdog;
		is_rst |=> st_r == ST_WDOG && !f_ready;
	endproperty
	a_wdog: assert property (p_wdog) else $error("reset did not arm watchdog");
	property p_restore;
		wdog_done |=> sprite_clear && invert_active == (table_r[4] != 8'h00) && cnt == '0;
	endproperty
	a_restore: assert property (p_restore) else $error("reset did not restore state");
endmodule // sdsq_top

`default_nettype wire

// ---- tb/sdsq_host_model.sv ----
// Purpose: host side of the serial display, sends bytes and takes replies
// Assumes: byte stream synchronous to mclk, flow bytes 11h and 13h
// Notes: RESUME_CYC and REPLY_CYC stand in for the 20 ms and 2 s limits
`include "sdsq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sdsq_host_model #(
	parameter int RESUME_CYC = 400,
	parameter int REPLY_CYC = 2000
) (
	input wire logic mclk,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data
);
	logic [7:0] all_q[$];
	logic [7:0] got_q[$];
	logic stopped = 1'b0;
	logic stall = 1'b0;
	logic hung = 1'b0;
	integer seed = 32'hA6020D53;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// slow and prompt acceptance mixed, stall holds every byte off
	always @(posedge mclk) begin
		tx_ready <= !stall && ($random(seed) % 3 != 0);
		if (tx_valid && tx_ready) begin
			all_q.push_back(tx_data);
			if (tx_data == `SDSQ_CHR_XOFF) stopped <= 1'b1;
			else if (tx_data == `SDSQ_CHR_XON) stopped <= 1'b0;
			else got_q.push_back(tx_data);
		end
	end
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		while (stopped && n < RESUME_CYC) begin
			@(posedge mclk);
			n++;
		end
		// lost resume byte: carry on as if it came
		if (stopped) stopped <= 1'b0;
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_data <= b;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!rx_ready && n < 100);
		if (!rx_ready) hung <= 1'b1;
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask
	task automatic query(input logic [7:0] idx, output logic [7:0] val);
		int n;
		got_q.delete();
		send(`SDSQ_PREFIX);
		send(`SDSQ_CMD_QUERY);
		send(idx);
		n = 0;
		while (got_q.size() == 0 && n < REPLY_CYC) begin
			@(posedge mclk);
			n++;
		end
		if (got_q.size() == 0) hung <= 1'b1;
		val = (got_q.size() == 0) ? 8'hxx : got_q[0];
	endtask
endmodule // sdsq_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the settings and query block
// Assumes: host model drives the receive side and takes replies
// Notes: watchdog shortened to 200 cycles so the buffer can fill meanwhile
`include "sdsq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] RO_I [6] = '{8'h20, 8'h21, 8'h22, 8'h40, 8'h41, 8'h81};
	localparam logic [7:0] RO_V [6] = '{8'h03, 8'h07, 8'h80, 8'h80, 8'h40, 8'h08};
	logic mclk, reset, rx_valid, rx_ready, tx_valid, tx_ready, args_pending;
	logic fwd_valid, fwd_is_code, invert_active, sprite_clear, scroll_up, query_error;
	logic [7:0] rx_data, tx_data, fwd_data, cursor_col, cursor_row, baud_sel, backlight, large_screen;
	logic [7:0] tbl [11];
	logic [7:0] v;
	int failures = 0, n_tests = 0, n_scroll = 0, n_clear = 0, n_qerr = 0, n_fwd = 0, n_code = 0, i, j, k;
	integer seed = 32'hA6020D53;
	always #10 mclk = ~mclk;
	sdsq_top #(.WDOG_CYCLES(200), .FW_MAJOR(RO_V[0]), .FW_MINOR(RO_V[1]), .SPR_BYTES(RO_V[2]),
		.WIDTH_PX(RO_V[3]), .HEIGHT_PX(RO_V[4]), .SPR0_HEIGHT(RO_V[5])) sdsq_top_inst (
		.mclk(mclk), .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .args_pending(args_pending),
		.fwd_valid(fwd_valid), .fwd_data(fwd_data), .fwd_is_code(fwd_is_code),
		.invert_active(invert_active), .sprite_clear(sprite_clear), .scroll_up(scroll_up),
		.query_error(query_error), .cursor_col(cursor_col), .cursor_row(cursor_row),
		.baud_sel(baud_sel), .backlight(backlight), .large_screen(large_screen));
	sdsq_host_model sdsq_host_model_inst (.mclk(mclk), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
	always @(posedge mclk) begin
		n_scroll += (scroll_up === 1'b1);
		n_clear += (sprite_clear === 1'b1);
		n_qerr += (query_error === 1'b1);
		n_fwd += (fwd_valid === 1'b1);
		n_code += (fwd_valid === 1'b1 && fwd_is_code === 1'b1);
		if (sdsq_host_model_inst.hung === 1'b1) begin
			failures++;
			wrap_up();
		end
	end
	function automatic logic [7:0] def_val(input int idx);
		case (idx)
			0: def_val = `SDSQ_DEF_MARKER;
			1: def_val = `SDSQ_DEF_BAUD;
			2: def_val = `SDSQ_DEF_BACKLIGHT;
			7: def_val = `SDSQ_DEF_RESUME;
			8: def_val = `SDSQ_DEF_STOP;
			default: def_val = `SDSQ_DEF_ZERO;
		endcase
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic q_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] got;
		sdsq_host_model_inst.query(idx, got);
		check("query reply", got, exp);
	endtask
	task automatic cmd(input logic [7:0] code);
		sdsq_host_model_inst.send(`SDSQ_PREFIX);
		sdsq_host_model_inst.send(code);
	endtask
	task automatic set_idx(input logic [7:0] idx, input logic [7:0] val);
		cmd(`SDSQ_CMD_SET);
		sdsq_host_model_inst.send(idx);
		sdsq_host_model_inst.send(val);
		if (idx < 11) tbl[idx] = val;
	endtask
	task automatic send_n(input logic [7:0] b, input int n);
		for (int m = 0; m < n; m++) sdsq_host_model_inst.send(b);
	endtask
	task automatic wait_clear(input int base);
		for (j = 0; j < 300 && n_clear == base; j++) @(posedge mclk);
		@(negedge mclk);
		check("sprite clears", 8'(n_clear - base), 8'h01);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		args_pending = 1'b0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		for (i = 0; i < 11; i++) tbl[i] = def_val(i);
		cmd(`SDSQ_CMD_RESET);
		wait_clear(0);
		check("baud_sel", baud_sel, tbl[1]);
		check("backlight", backlight, tbl[2]);
		for (i = 0; i < 11; i++)
			if (i != 5) q_chk(8'(i), tbl[i]);
		k = n_qerr;
		q_chk(`SDSQ_IDX_RESERVED, `SDSQ_ERR_BYTE);
		check("query_error pulses", 8'(n_qerr - k), 8'h01);
		for (i = 0; i < 6; i++) begin
			set_idx(RO_I[i], ~RO_V[i]);
			q_chk(RO_I[i], RO_V[i]);
		end
		$display("test defaults done");
		// fill positions stay put here, a random one would stall the host
		for (i = 0; i < 11; i++) begin
			if (i == 5 || i == 7 || i == 8) continue;
			v = 8'($random(seed));
			if (v == `SDSQ_CHR_XON || v == `SDSQ_CHR_XOFF) v = 8'h00;
			set_idx(8'(i), v);
		end
		set_idx(`SDSQ_IDX_INVERT, 8'h01);
		for (i = 0; i < 11; i++)
			if (i != 5) q_chk(8'(i), tbl[i]);
		check("baud_sel", baud_sel, tbl[1]);
		check("large_screen", large_screen, tbl[10]);
		check("invert_active", {7'h00, invert_active}, 8'h00);
		$display("test set done");
		set_idx(`SDSQ_IDX_RESUME, 8'h00);
		set_idx(`SDSQ_IDX_STOP, 8'h01);
		sdsq_host_model_inst.all_q.delete();
		sdsq_host_model_inst.send(8'h41);
		for (j = 0; j < 200 && sdsq_host_model_inst.all_q.size() < 2; j++) @(posedge mclk);
		check("first flow byte", sdsq_host_model_inst.all_q[0], `SDSQ_CHR_XOFF);
		check("second flow byte", sdsq_host_model_inst.all_q[1], `SDSQ_CHR_XON);
		set_idx(`SDSQ_IDX_STOP, `SDSQ_DEF_STOP);
		set_idx(`SDSQ_IDX_RESUME, `SDSQ_DEF_RESUME);
		$display("test flow done");
		set_idx(`SDSQ_IDX_INVERT, 8'h00);
		cmd(`SDSQ_CMD_REVERSE);
		for (j = 0; j < 100 && invert_active !== 1'b1; j++) @(posedge mclk);
		check("invert_active", {7'h00, invert_active}, 8'h01);
		// unknown code leaves for the drawing blocks, flagged as a code
		i = n_code;
		cmd(8'h55);
		for (j = 0; j < 100 && n_code == i; j++) @(posedge mclk);
		check("code pulses", 8'(n_code - i), 8'h01);
		check("fwd_data code", fwd_data, 8'h55);
		i = n_fwd;
		k = n_clear;
		args_pending <= 1'b1;
		cmd(`SDSQ_CMD_RESET);
		for (j = 0; j < 100 && n_fwd < i + 2; j++) @(posedge mclk);
		args_pending <= 1'b0;
		check("forwarded args", 8'(n_fwd - i), 8'h02);
		check("early clears", 8'(n_clear - k), 8'h00);
		check("fwd_data arg", fwd_data, `SDSQ_CMD_RESET);
		// host holds replies off so the watchdog wait fills the buffer
		sdsq_host_model_inst.stall = 1'b1;
		cmd(`SDSQ_CMD_RESET);
		send_n(8'h41, 32);
		@(negedge mclk);
		check("rx_ready full", {7'h00, rx_ready}, 8'h00);
		sdsq_host_model_inst.stall = 1'b0;
		wait_clear(k);
		check("invert_active", {7'h00, invert_active}, 8'h00);
		check("cursor_col", cursor_col, 8'h00);
		check("cursor_row", cursor_row, 8'h00);
		q_chk(`SDSQ_IDX_BAUD, tbl[1]);
		$display("test reset done");
		set_idx(`SDSQ_IDX_LINE_END, 8'h00);
		set_idx(`SDSQ_IDX_SCROLL, 8'h00);
		send_n(`SDSQ_CHR_CR, 1);
		send_n(8'h41, 1);
		send_n(`SDSQ_CHR_LF, 1);
		q_chk(`SDSQ_IDX_LINE_END, 8'h00);
		check("col after LF", cursor_col, 8'h00);
		check("row after LF", cursor_row, 8'h01);
		set_idx(`SDSQ_IDX_LINE_END, 8'h01);
		send_n(8'h41, 1);
		send_n(`SDSQ_CHR_LF, 1);
		q_chk(`SDSQ_IDX_LINE_END, 8'h01);
		check("col after LF", cursor_col, 8'h01);
		check("row after LF", cursor_row, 8'h02);
		k = n_scroll;
		send_n(`SDSQ_CHR_LF, 6);
		q_chk(`SDSQ_IDX_SCROLL, 8'h00);
		check("row after wrap", cursor_row, 8'h00);
		check("scroll pulses", 8'(n_scroll - k), 8'h00);
		set_idx(`SDSQ_IDX_SCROLL, 8'h01);
		send_n(`SDSQ_CHR_LF, 8);
		q_chk(`SDSQ_IDX_SCROLL, 8'h01);
		check("row after scroll", cursor_row, 8'h07);
		check("scroll pulses", 8'(n_scroll - k), 8'h01);
		$display("test text done");
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
